// file: data_memory_indirect_access_tb_top.sv
// testbench for the data memory with indirect access
`timescale 1ns/1ns
module data_memory_indirect_access_tb_top;
  import dmia_pkg::*;
  logic sys_clk;
  logic sys_rst;
  logic ce;
  dmia_req_t req;
  dmia_alu_t alu;
  logic [DATA_W-1:0] rd_data;
  logic rd_valid;
  logic [DATA_W-1:0] acc_value;
  logic [DATA_W-1:0] q;
  int err_total;
  int total_checks;
  logic [ADDR_W-1:0] unused_a [3] = '{7'h04, 7'h06, 7'h5F};

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  dmia_cpu_model cpu_u (.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid), .ce(ce), .req(req), .alu(alu));
  dmia_data_memory dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .req(req), .alu(alu),
    .rd_data(rd_data), .rd_valid(rd_valid), .acc_value(acc_value));

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] x;
    cpu_u.access(1'b0, 1'b1, a, d, 1'b0, 8'h00, x);
    cmp({7'h00, cpu_u.got_valid}, 8'h00);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] x;
    cpu_u.access(1'b1, 1'b0, a, 8'h00, 1'b0, 8'h00, x);
    cmp(x, e);
    cmp({7'h00, cpu_u.got_valid}, 8'h01);
  endtask : rd_chk

  // bounded run, a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    err_total = 0;
    total_checks = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    cmp({7'h00, rd_valid}, 8'h00);
    cmp(acc_value, ACC_RST);
    rd_chk(ADDR_PTR_A, 8'h80);
    rd_chk(ADDR_PTR_B, 8'h80);
    // ram not cleared by reset, so write before any read
    for (int i = 0; i < GP_DEPTH_DEF; i++) wr(7'(GP_BASE_DEF + i), 8'(8'hA5 ^ i));
    for (int i = 0; i < GP_DEPTH_DEF; i++) rd_chk(7'(GP_BASE_DEF + i), 8'(8'hA5 ^ i));
    wr(ADDR_PTR_A, 8'hE1);
    rd_chk(ADDR_PTR_A, 8'hE1);
    rd_chk(ADDR_WIN_A, 8'hA4);
    wr(ADDR_PTR_B, 8'h7E);
    rd_chk(ADDR_PTR_B, 8'hFE);
    wr(ADDR_WIN_B, 8'h3C);
    rd_chk(7'h7E, 8'h3C);
    rd_chk(ADDR_WIN_B, 8'h3C);
    wr(ADDR_PTR_A, 8'h02);
    wr(ADDR_WIN_A, 8'h77);
    rd_chk(ADDR_WIN_A, 8'h00);
    rd_chk(7'h7E, 8'h3C);
    wr(ADDR_PTR_A, 8'h00);
    rd_chk(ADDR_WIN_A, 8'h00);
    foreach (unused_a[i]) begin
      wr(unused_a[i], 8'hAA);
      rd_chk(unused_a[i], 8'h00);
    end
    cpu_u.access(1'b0, 1'b0, 7'h00, 8'h00, 1'b1, 8'h5A, q);
    cmp(acc_value, 8'h5A);
    rd_chk(ADDR_ACC, 8'h5A);
    cpu_u.access(1'b0, 1'b1, ADDR_ACC, 8'h11, 1'b1, 8'h22, q);
    cmp(acc_value, 8'h22);
    // copy 7E to 60 through the accumulator
    cpu_u.access(1'b1, 1'b0, 7'h7E, 8'h00, 1'b0, 8'h00, q);
    wr(ADDR_ACC, q);
    cmp(acc_value, 8'h3C);
    wr(7'h60, acc_value);
    rd_chk(7'h60, 8'h3C);
    // back-to-back pairs, direct and through both windows
    cpu_u.write_read(ADDR_WIN_B, 8'h81, 7'h7E, q);
    cmp(q, 8'h81);
    cpu_u.write_read(7'h65, 8'h5C, 7'h65, q);
    cmp(q, 8'h5C);
    wr(ADDR_PTR_A, 8'h65);
    cpu_u.write_read(7'h65, 8'hC3, ADDR_WIN_A, q);
    cmp(q, 8'hC3);
    cpu_u.write_read(ADDR_PTR_B, 8'h13, ADDR_PTR_B, q);
    cmp(q, 8'h93);
    // window a aimed at the accumulator
    wr(ADDR_PTR_A, 8'h05);
    wr(ADDR_WIN_A, 8'h6B);
    cmp(acc_value, 8'h6B);
    rd_chk(ADDR_WIN_A, 8'h6B);
    // read and write in one cycle: old value returned, write applied
    cpu_u.access(1'b1, 1'b1, ADDR_PTR_A, 8'hFF, 1'b0, 8'h00, q);
    cmp(q, 8'h85);
    rd_chk(ADDR_PTR_A, 8'hFF);
    // clock enable low: neither ram nor accumulator moves
    cpu_u.stalled_write(7'h60, 8'hEE);
    cpu_u.stalled_write(ADDR_ACC, 8'hEE);
    rd_chk(7'h60, 8'h3C);
    cmp(acc_value, 8'h6B);
    // reset in mid-run
    sys_rst = 1'b1;
    @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    cmp(acc_value, ACC_RST);
    rd_chk(ADDR_PTR_A, 8'h80);
    rd_chk(ADDR_PTR_B, 8'h80);
    rd_chk(ADDR_WIN_B, 8'h00);
    print_verdict();
  end
endmodule : data_memory_indirect_access_tb_top

// file: dmia_cpu_model.sv
// cpu-side model issuing data memory accesses
`timescale 1ns/1ns
module dmia_cpu_model
  import dmia_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_valid,
  output logic ce,
  output dmia_req_t req,
  output dmia_alu_t alu
);
  logic got_valid;
  initial begin
    ce = 1'b1;
    got_valid = 1'b0;
    req = '0;
    alu = '0;
  end
  // one access per instruction, so copies pass the accumulator
  // idle cycle after each access keeps one assignment per step
  task automatic access(input logic r, input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic aw, input logic [DATA_W-1:0] res, output logic [DATA_W-1:0] q);
    req = '{rd: r, wr: w, addr: a, wdata: d};
    alu = '{we: aw, result: res};
    @(posedge sys_clk);
    #1;
    q = rd_data;
    got_valid = rd_valid;
    req = '0;
    alu = '0;
    @(posedge sys_clk);
    #1;
  endtask : access
  // write then read on back-to-back edges, no idle cycle between
  task automatic write_read(input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] d,
    input logic [ADDR_W-1:0] ra, output logic [DATA_W-1:0] q);
    req = '{rd: 1'b0, wr: 1'b1, addr: wa, wdata: d};
    @(posedge sys_clk);
    #1;
    req = '{rd: 1'b1, wr: 1'b0, addr: ra, wdata: 8'h00};
    @(posedge sys_clk);
    #1;
    q = rd_data;
    got_valid = rd_valid;
    req = '0;
    @(posedge sys_clk);
    #1;
  endtask : write_read
  // write and unit load offered while the clock enable is low
  task automatic stalled_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    ce = 1'b0;
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    alu = '{we: 1'b1, result: d};
    @(posedge sys_clk);
    #1;
    ce = 1'b1;
    req = '0;
    alu = '0;
    @(posedge sys_clk);
    #1;
  endtask : stalled_write
endmodule : dmia_cpu_model

// file: dmia_data_memory.sv
// data memory with pointer-based indirect access and accumulator
//
// How it works
// - accumulator and general area hold eight-bit volatile bytes, pointers keep seven bits
// - fixed register area plus read-write general area
// - only listed registers writable, others protected
// - window addresses hold no storage at all
// - window accesses redirect through their paired pointer
// - window reached indirectly reads zero, ignores write
// - pointers are ordinary read-write-modify registers
// - pointer bit seven ignored, always reads one
// - arithmetic results always land in accumulator
// - one access per cycle, moves via accumulator
`timescale 1ns/1ns
module dmia_data_memory
  import dmia_pkg::*;
#(
  parameter int GP_BASE = GP_BASE_DEF,
  parameter int GP_DEPTH = GP_DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire dmia_req_t req,
  input wire dmia_alu_t alu,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic [DATA_W-1:0] acc_value
);

  localparam int IDX_W = (GP_DEPTH > 1) ? $clog2(GP_DEPTH) : 1;
  localparam int GP_END = GP_BASE + GP_DEPTH;

  initial begin
    if (GP_BASE <= SFR_LAST || GP_END > (1 << ADDR_W) || GP_DEPTH < 2) begin
      $error("dmia_data_memory: general area does not fit the address space");
    end
  end

  dmia_state_t st_q;
  dmia_state_t st_d;

  logic indirect;
  logic [ADDR_W-1:0] eff_addr;
  dmia_region_t eff_kind;
  logic [IDX_W-1:0] gp_idx;
  logic gp_we;
  logic [DATA_W-1:0] gp_rdata;
  logic [ADDR_W-1:0] gp_off;

  // classify an effective address
  function automatic dmia_region_t region_of(input logic [ADDR_W-1:0] a);
    dmia_region_t r;
    r = RG_NONE;
    if (a == ADDR_WIN_A || a == ADDR_WIN_B) begin
      r = RG_WINDOW;
    end else if (a == ADDR_PTR_A) begin
      r = RG_PTR_A;
    end else if (a == ADDR_PTR_B) begin
      r = RG_PTR_B;
    end else if (a == ADDR_ACC) begin
      r = RG_ACC;
    end else if (int'(a) >= GP_BASE && int'(a) < GP_END) begin
      r = RG_GP;
    end
    return r;
  endfunction : region_of

  // address resolution
  always_comb begin
    indirect = 1'b0;
    eff_addr = req.addr;
    if (req.addr == ADDR_WIN_A) begin
      // bit seven of the pointer is not stored, so it cannot reach the address
      indirect = 1'b1;
      eff_addr = st_q.ptr_a;
    end else if (req.addr == ADDR_WIN_B) begin
      indirect = 1'b1;
      eff_addr = st_q.ptr_b;
    end
    eff_kind = region_of(eff_addr);
  end

  // wraps below the base, but region_of keeps such addresses away from the ram
  assign gp_off = eff_addr - ADDR_W'(GP_BASE);
  assign gp_idx = gp_off[IDX_W-1:0];
  assign gp_we = req.wr && (eff_kind == RG_GP);

  dmia_gp_ram #(
    .DEPTH(GP_DEPTH),
    .IDX_W(IDX_W)
  ) u_gp_ram (
    .sys_clk(sys_clk),
    .ce(ce),
    .we(gp_we),
    .idx(gp_idx),
    .wdata(req.wdata),
    .rdata(gp_rdata)
  );

  // next-state logic; a single request port means no register-to-register move
  always_comb begin
    st_d = st_q;
    st_d.rvalid = req.rd;
    if (req.rd) begin
      case (eff_kind)
        RG_PTR_A: begin
          st_d.rdata = {PTR_FORCED_VAL, st_q.ptr_a};
        end
        RG_PTR_B: begin
          st_d.rdata = {PTR_FORCED_VAL, st_q.ptr_b};
        end
        RG_ACC: begin
          st_d.rdata = st_q.acc;
        end
        RG_GP: begin
          st_d.rdata = gp_rdata;
        end
        RG_WINDOW: begin
          // only reachable indirectly: a window behind a window has no storage
          st_d.rdata = UNMAPPED_VAL;
        end
        default: begin
          st_d.rdata = UNMAPPED_VAL;
        end
      endcase
    end
    if (req.wr) begin
      // writes outside the listed registers are dropped, which protects the rest
      case (eff_kind)
        RG_PTR_A: begin
          st_d.ptr_a = req.wdata[ADDR_W-1:0];
        end
        RG_PTR_B: begin
          st_d.ptr_b = req.wdata[ADDR_W-1:0];
        end
        RG_ACC: begin
          st_d.acc = req.wdata;
        end
        RG_WINDOW: begin
          st_d.acc = st_q.acc;
        end
        default: begin
          st_d.acc = st_q.acc;
        end
      endcase
    end
    // the unit result wins over a same-cycle bus write to the accumulator
    if (alu.we) begin
      st_d.acc = alu.result;
    end
  end

  always_ff @(posedge sys_clk) begin
    // reset does not wait for the enable, so a frozen block still clears
    if (sys_rst) begin
      st_q <= '{ptr_a: PTR_RST, ptr_b: PTR_RST, acc: ACC_RST, rdata: RDATA_RST, rvalid: 1'b0};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rdata;
  assign rd_valid = st_q.rvalid;
  assign acc_value = st_q.acc;

  // checks
  sequence seq_gp_write;
    ce && req.wr && !req.rd && region_of(req.addr) == RG_GP;
  endsequence

  sequence seq_gp_write_read;
    seq_gp_write ##1 (ce && req.rd && !req.wr && req.addr == $past(req.addr));
  endsequence

  sequence seq_ind_a_to(logic [ADDR_W-1:0] target);
    ce && req.addr == ADDR_WIN_A && st_q.ptr_a == target;
  endsequence

  property p_gp_roundtrip;
    @(posedge sys_clk) disable iff (sys_rst)
      seq_gp_write_read |=> rd_data == $past(req.wdata, 2);
  endproperty

  property p_win_write_redirect;
    @(posedge sys_clk) disable iff (sys_rst)
      seq_ind_a_to(ADDR_ACC) ##0 (req.wr && !alu.we) |=> acc_value == $past(req.wdata);
  endproperty

  chk_gp_write_read: assert property (p_gp_roundtrip)
    else $error("general area byte not read back");

  chk_window_redirect: assert property (p_win_write_redirect)
    else $error("window write did not reach pointer target");

  chk_pointer_bit_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.rd && req.addr == ADDR_PTR_A |=> rd_data == {PTR_FORCED_VAL, $past(st_q.ptr_a)})
    else $error("pointer read wrong or bit seven not one");

  chk_window_self_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.rd && indirect && region_of(eff_addr) == RG_WINDOW |=> rd_data == UNMAPPED_VAL)
    else $error("window read through pointer not zero");

  chk_window_no_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.wr && !alu.we && indirect && region_of(eff_addr) == RG_WINDOW
      |=> $stable(st_q.ptr_a) && $stable(st_q.ptr_b) && $stable(acc_value))
    else $error("window write through pointer changed state");

  chk_pointer_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.wr && req.addr == ADDR_PTR_B ##1 ce && req.rd && !req.wr && req.addr == ADDR_PTR_B
      |=> rd_data == {PTR_FORCED_VAL, $past(req.wdata[ADDR_W-1:0], 2)})
    else $error("pointer did not keep written value");

  chk_alu_to_acc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && alu.we |=> acc_value == $past(alu.result))
    else $error("unit result missing from accumulator");

  chk_unused_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.rd && !indirect && region_of(req.addr) == RG_NONE |=> rd_data == UNMAPPED_VAL)
    else $error("unused address did not read zero");

  chk_protected_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.wr && !alu.we && region_of(eff_addr) == RG_NONE
      |=> $stable(st_q.ptr_a) && $stable(st_q.ptr_b) && $stable(acc_value))
    else $error("write to protected address changed state");

  chk_read_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.rd |=> rd_valid)
    else $error("read answer not flagged");

  chk_freeze: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ce |=> $stable(st_q))
    else $error("state moved while clock enable low");

  // indirect pairs are checked end to end, so a wrong pointer path shows in the data
  sequence seq_win_b_gp_write;
    ce && req.wr && !req.rd && req.addr == ADDR_WIN_B && region_of(st_q.ptr_b) == RG_GP;
  endsequence

  sequence seq_win_b_write_read;
    seq_win_b_gp_write ##1 (ce && req.rd && !req.wr && req.addr == $past(st_q.ptr_b));
  endsequence

  sequence seq_gp_write_win_a_read;
    seq_gp_write ##1 (ce && req.rd && !req.wr && req.addr == ADDR_WIN_A && st_q.ptr_a == $past(req.addr));
  endsequence

  property p_win_b_lands;
    @(posedge sys_clk) disable iff (sys_rst)
      seq_win_b_write_read |=> rd_data == $past(req.wdata, 2);
  endproperty

  property p_win_a_fetches;
    @(posedge sys_clk) disable iff (sys_rst)
      seq_gp_write_win_a_read |=> rd_data == $past(req.wdata, 2);
  endproperty

  chk_window_b_write: assert property (p_win_b_lands)
    else $error("window write did not land at pointer target");

  chk_window_a_read: assert property (p_win_a_fetches)
    else $error("window read did not fetch pointer target");

  chk_pointer_b_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.rd && req.addr == ADDR_PTR_B |=> rd_data == {PTR_FORCED_VAL, $past(st_q.ptr_b)})
    else $error("second pointer read wrong or bit seven not one");

  chk_window_b_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.rd && req.addr == ADDR_WIN_B && region_of(st_q.ptr_b) == RG_WINDOW |=> rd_data == UNMAPPED_VAL)
    else $error("second window read through pointer not zero");

  chk_acc_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.rd && req.addr == ADDR_ACC |=> rd_data == $past(acc_value))
    else $error("accumulator read wrong");

  // the only way between two registers is through here
  chk_acc_bus_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && req.wr && !alu.we && req.addr == ADDR_ACC |=> acc_value == $past(req.wdata))
    else $error("bus write missing from accumulator");

  chk_pointer_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && !req.wr |=> $stable(st_q.ptr_a) && $stable(st_q.ptr_b))
    else $error("pointer moved without a write");

  chk_valid_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && !req.rd |=> !rd_valid)
    else $error("read flag raised without a read");

  // a consumer may sample the answer late, so it must stand
  chk_rdata_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && !req.rd |=> $stable(rd_data))
    else $error("read answer changed without a read");

  // ram is left alone by reset, everything else returns to known values
  chk_reset_values: assert property (@(posedge sys_clk)
    sys_rst |=> rd_data == RDATA_RST && !rd_valid && acc_value == ACC_RST && st_q.ptr_a == PTR_RST
      && st_q.ptr_b == PTR_RST)
    else $error("state not cleared by reset");

endmodule : dmia_data_memory

// file: dmia_gp_ram.sv
// general-purpose byte array of the data memory
`timescale 1ns/1ns
module dmia_gp_ram
  import dmia_pkg::*;
#(
  parameter int DEPTH = GP_DEPTH_DEF,
  parameter int IDX_W = $clog2(GP_DEPTH_DEF)
) (
  input wire logic sys_clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [IDX_W-1:0] idx,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  initial begin
    if (DEPTH < 2 || (1 << IDX_W) < DEPTH) begin
      $error("dmia_gp_ram: depth and index width do not fit");
    end
  end

  // volatile: contents are not cleared by reset
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (ce && we) begin
      mem[idx] <= wdata;
    end
  end

  // combinational read so the top can register the answer itself
  assign rdata = (int'(idx) < DEPTH) ? mem[idx] : UNMAPPED_VAL;

endmodule : dmia_gp_ram

// file: dmia_pkg.sv
// shared constants and types for the data memory with indirect access
package dmia_pkg;

  // memory geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int SFR_LAST = 'h5F;
  localparam int GP_BASE_DEF = 'h60;
  localparam int GP_DEPTH_DEF = 32;

  // fixed special-function addresses
  localparam logic [ADDR_W-1:0] ADDR_WIN_A = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_PTR_A = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_WIN_B = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_PTR_B = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_ACC = 7'h05;

  // pointer field layout and reset values
  localparam int PTR_FORCED_BIT = 7;
  localparam logic PTR_FORCED_VAL = 1'b1;
  localparam logic [ADDR_W-1:0] PTR_RST = 7'h00;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_VAL = 8'h00;

  // one access from the instruction execution logic
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmia_req_t;

  // result of the arithmetic and logic unit
  typedef struct packed {
    logic we;
    logic [DATA_W-1:0] result;
  } dmia_alu_t;

  // what an effective address lands on
  typedef enum logic [2:0] {
    RG_NONE,
    RG_WINDOW,
    RG_PTR_A,
    RG_PTR_B,
    RG_ACC,
    RG_GP
  } dmia_region_t;

  // all state of the top module
  typedef struct packed {
    logic [ADDR_W-1:0] ptr_a;
    logic [ADDR_W-1:0] ptr_b;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } dmia_state_t;

endpackage : dmia_pkg

// file: dmia_tail_unused.sv
// (no content)
